// ---- rgtd_buf.v ----
`timescale 1ns/1ps

module rgtd_buf #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             i_clk,
  input  wire             i_rst_n,
  // Fill side
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);

  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg             wr_ptr;
  reg             rd_ptr;
  reg [1:0]       count;
  wire            push;
  wire            pop;

  // Full and empty come straight from the count
  assign o_in_ready  = (count != 2'h2);
  assign o_out_valid = (count != 2'h0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = rd_ptr ? slot1 : slot0;

  // Two slots so a stalled receiver never drops a word
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      slot0  <= {WIDTH{1'b0}};
      slot1  <= {WIDTH{1'b0}};
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push && !wr_ptr)
        slot0 <= i_in_data;
      if (push && wr_ptr)
        slot1 <= i_in_data;
      if (push)
        wr_ptr <= ~wr_ptr;
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end

endmodule // rgtd_buf

// ---- rgtd_chan.v ----
`timescale 1ns/1ps
`include "rgtd_map.vh"

module rgtd_chan (
  // Channel block and texel position
  input  wire [63:0] i_blk,
  input  wire [3:0]  i_pos,
  input  wire        i_signed,
  // Blend description
  output reg  [3:0]  o_w0,
  output reg  [3:0]  o_w1,
  output wire        o_hi,
  output reg  [1:0]  o_lim,
  output wire [8:0]  o_ep0,
  output wire [8:0]  o_ep1
);

  wire [7:0]  code0;
  wire [7:0]  code1;
  wire [47:0] idx;
  wire [2:0]  sel;
  wire        gt;

  // Byte 0 and byte 1 are endpoints, bytes 2..7 the little-endian index
  assign code0 = i_blk[7:0];                                     // RQ5
  assign code1 = i_blk[15:8];                                    // RQ5
  assign idx   = i_blk[`RGTD_IDX_LSB +: `RGTD_IDX_BITS];         // RQ6
  assign sel   = idx[{i_pos, 1'b0} + {2'h0, i_pos} +: `RGTD_SEL_BITS]; // RQ7

  // Raw codes are compared, so -127 against -128 takes the seven-step set
  assign gt = i_signed ? ($signed(code0) > $signed(code1)) : (code0 > code1); // RQ15
  assign o_hi = gt;

  // Signed -128 is clamped to -127 so both give -1.0 after scaling
  assign o_ep0 = i_signed ? ((code0 == `RGTD_SNORM_NEG) ? {1'b1, `RGTD_SNORM_CLAMP}
                 : {code0[7], code0}) : {1'b0, code0};          // RQ14 RQ11
  assign o_ep1 = i_signed ? ((code1 == `RGTD_SNORM_NEG) ? {1'b1, `RGTD_SNORM_CLAMP}
                 : {code1[7], code1}) : {1'b0, code1};          // RQ14 RQ11

  // Weights for each selector, numerator over seven or five
  always @* begin
    o_w0  = 4'h0;
    o_w1  = 4'h0;
    o_lim = `RGTD_LIM_NONE;
    if (gt) begin
      case (sel)
        3'h0: begin o_w0 = `RGTD_DEN_HI; o_w1 = 4'h0; end        // RQ8
        3'h1: begin o_w0 = 4'h0; o_w1 = `RGTD_DEN_HI; end        // RQ8
        default: begin
          o_w0 = 4'h8 - {1'b0, sel};                             // RQ8
          o_w1 = {1'b0, sel} - 4'h1;                             // RQ8
        end
      endcase
    end else begin
      case (sel)
        3'h0: begin o_w0 = `RGTD_DEN_LO; o_w1 = 4'h0; end        // RQ9
        3'h1: begin o_w0 = 4'h0; o_w1 = `RGTD_DEN_LO; end        // RQ9
        3'h2: begin o_w0 = 4'h3; o_w1 = 4'h2; end                // RQ10
        3'h3: begin o_w0 = 4'h4; o_w1 = 4'h1; end                // RQ9
        3'h4: begin o_w0 = 4'h2; o_w1 = 4'h3; end                // RQ9
        3'h5: begin o_w0 = 4'h1; o_w1 = 4'h4; end                // RQ9
        3'h6: o_lim = `RGTD_LIM_MIN;                             // RQ9
        default: o_lim = `RGTD_LIM_MAX;                          // RQ9
      endcase
    end
  end

endmodule // rgtd_chan

// ---- rgtd_map.vh ----
`ifndef RGTD_MAP_VH
`define RGTD_MAP_VH

// Format select codes
`define RGTD_FMT_U1        2'h0
`define RGTD_FMT_S1        2'h1
`define RGTD_FMT_U2        2'h2
`define RGTD_FMT_S2        2'h3

// Block geometry
`define RGTD_TILE_SHIFT    2
`define RGTD_TILE_MASK     2'h3
`define RGTD_BLK1_SHIFT    3
`define RGTD_BLK2_SHIFT    4
`define RGTD_CHAN_BITS     64
`define RGTD_IDX_LSB       16
`define RGTD_IDX_BITS      48
`define RGTD_SEL_BITS      3

// Blend denominators and endpoint full scale
`define RGTD_DEN_HI        4'h7
`define RGTD_DEN_LO        4'h5
`define RGTD_UNORM_MAX     8'hFF
`define RGTD_SNORM_MAX     8'h7F
`define RGTD_SNORM_NEG     8'h80
`define RGTD_SNORM_CLAMP   8'h81

// Output fixed point, 1.0 is 2^14
`define RGTD_VAL_ONE       16'h4000
`define RGTD_VAL_NEG_ONE   16'hC000
`define RGTD_VAL_ZERO      16'h0000
`define RGTD_FRAC_SHIFT    20
`define RGTD_SCALE_NUM     64'h0000000400000000

// Limit selector codes from the channel decoder
`define RGTD_LIM_NONE      2'h0
`define RGTD_LIM_MIN       2'h1
`define RGTD_LIM_MAX       2'h2

`endif

// ---- rgtd_mem_model.sv ----
`timescale 1ns/1ps

module rgtd_mem_model (
  // Clock, reset and pacing
  input  wire logic         i_clk, i_rst_n, i_slow,
  // Read request and block to return
  input  wire logic         i_mem_valid, i_mem_wide,
  input  wire logic [127:0] i_blk,
  // Answer
  output logic              o_mem_ready, o_mem_rvalid,
  output logic [127:0]      o_mem_rdata
);
  integer     seed = 51694;
  logic       pend;
  logic       wide;
  logic [2:0] lat;

  // One read at a time, answered after one to eight cycles when slow
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_mem_ready  <= 1'b0;
      o_mem_rvalid <= 1'b0;
      o_mem_rdata  <= 128'h0;
      pend         <= 1'b0;
      wide         <= 1'b0;
      lat          <= 3'h0;
    end else begin
      o_mem_rvalid <= 1'b0;
      o_mem_rdata  <= ~o_mem_rdata; // Stale data flips each cycle, so it repeats the last answer only every other cycle
      if (pend) begin
        lat <= lat - 3'h1;
        if (lat == 3'h0) begin
          pend         <= 1'b0;
          o_mem_rvalid <= 1'b1;
          // Narrow blocks carry only 64 bits; the upper half is junk
          o_mem_rdata  <= wide ? i_blk : {~i_blk[127:64], i_blk[63:0]};
        end
      end else if (i_mem_valid && o_mem_ready) begin
        pend        <= 1'b1;
        wide        <= i_mem_wide;
        o_mem_ready <= 1'b0;
        lat         <= i_slow ? 3'($random(seed)) : 3'h0;
      end else begin
        o_mem_ready <= i_slow ? 1'($random(seed)) : 1'b1;
      end
    end
  end
endmodule // rgtd_mem_model

// ---- rgtd_top.v ----
// Behaviour
// RQ1: Image is a raster of 4x4 blocks, 64 or 128 bits each.
// RQ2: Block byte offset is size times (ceil(w/4)*floor(y/4)+floor(x/4)).
// RQ3: Texel inside block chosen by x mod 4 and y mod 4.
// RQ4: Texels outside the image may decode to anything; they are flagged.
// RQ5: Channel block bytes: endpoint 0, endpoint 1, six index bytes.
// RQ6: Index bytes form a 48-bit little-endian vector.
// RQ7: Selector is three bits at 3*(4y+x) of that vector.
// RQ8: First code greater: endpoints, then six seventh-step blends.
// RQ9: Otherwise endpoints, fifth-step blends, then range minimum and maximum.
// RQ10: In the fifth-step set selector 2 gives (3a+2b)/5.
// RQ11: Unsigned endpoint codes are plain unsigned bytes.
// RQ12: Unsigned value is code divided by 255.
// RQ13: One-channel formats return (R,0,0,1).
// RQ14: Signed value is code/127, -128 gives -1.0; range is -1..1.
// RQ15: Signed -127 versus -128 comparison may go either way.
// RQ16: Encoders should avoid signed blocks with -127 then -128.
// RQ17: Two-channel unsigned: low half is red, high half green.
// RQ18: Two-channel signed: both halves decoded signed, red then green.
// RQ19: Two-channel formats return (R,G,0,1).
// RQ20: Requester supplies format, image size and texel coordinates.
`timescale 1ns/1ps
`include "rgtd_map.vh"

module rgtd_top #(
  parameter CW = 16,
  parameter AW = 32,
  parameter TW = 8
) (
  // Clock and reset
  input  wire          i_clk,
  input  wire          i_rst_n,
  // Texel request
  input  wire          i_req_valid,
  output wire          o_req_ready,
  input  wire [1:0]    i_req_fmt,
  input  wire [AW-1:0] i_req_base,
  input  wire [CW-1:0] i_req_width,
  input  wire [CW-1:0] i_req_height,
  input  wire [CW-1:0] i_req_x,
  input  wire [CW-1:0] i_req_y,
  input  wire [TW-1:0] i_req_tag,
  // Compressed memory read
  output wire          o_mem_valid,
  input  wire          i_mem_ready,
  output wire [AW-1:0] o_mem_addr,
  output wire          o_mem_wide,
  input  wire          i_mem_rvalid,
  input  wire [127:0]  i_mem_rdata,
  // Decoded texel
  output wire          o_tex_valid,
  input  wire          i_tex_ready,
  output wire [15:0]   o_tex_r,
  output wire [15:0]   o_tex_g,
  output wire [15:0]   o_tex_b,
  output wire [15:0]   o_tex_a,
  output wire          o_tex_pad,
  output wire [TW-1:0] o_tex_tag
);

  // Buffer word: tag, pad, alpha, blue, green, red
  localparam BW = 4 * 16 + 1 + TW;

  // States
  localparam ST_IDLE  = 3'h0;
  localparam ST_FETCH = 3'h1;
  localparam ST_WAIT  = 3'h2;
  localparam ST_CALC  = 3'h3;
  localparam ST_PUSH  = 3'h4;

  // Reciprocal multipliers: 2^34 / (den * full scale), rounded
  // Divisors are denominator times endpoint full scale
  localparam [63:0] DIV_U7 = 64'h0000000000000000 + `RGTD_DEN_HI * `RGTD_UNORM_MAX;
  localparam [63:0] DIV_U5 = 64'h0000000000000000 + `RGTD_DEN_LO * `RGTD_UNORM_MAX;
  localparam [63:0] DIV_S7 = 64'h0000000000000000 + `RGTD_DEN_HI * `RGTD_SNORM_MAX;
  localparam [63:0] DIV_S5 = 64'h0000000000000000 + `RGTD_DEN_LO * `RGTD_SNORM_MAX;

  // Quotients at full width
  localparam [63:0] K_U7_W = (`RGTD_SCALE_NUM + DIV_U7 / 64'h2) / DIV_U7;
  localparam [63:0] K_U5_W = (`RGTD_SCALE_NUM + DIV_U5 / 64'h2) / DIV_U5;
  localparam [63:0] K_S7_W = (`RGTD_SCALE_NUM + DIV_S7 / 64'h2) / DIV_S7;
  localparam [63:0] K_S5_W = (`RGTD_SCALE_NUM + DIV_S5 / 64'h2) / DIV_S5;

  // The largest multiplier needs 25 bits
  localparam [25:0] K_U7 = K_U7_W[25:0];
  localparam [25:0] K_U5 = K_U5_W[25:0];
  localparam [25:0] K_S7 = K_S7_W[25:0];
  localparam [25:0] K_S5 = K_S5_W[25:0];

  // Half an output step, added before the shift
  localparam [39:0] ROUND_HALF = 40'h0000080000;

  // Sequencer
  reg  [2:0]    state;
  reg  [2:0]    next_state;

  // Request fields held for the texel in flight
  reg  [1:0]    fmt;
  reg  [AW-1:0] addr;
  reg  [3:0]    pos;
  reg           pad;
  reg  [TW-1:0] tag;

  // Block as returned by memory
  reg  [127:0]  blk;

  // Decoded channels waiting for the buffer
  reg  [15:0]   val_r;
  reg  [15:0]   val_g;

  // Format flags
  wire          fmt_signed;
  wire          fmt_dual;

  // Address arithmetic
  wire [CW-1:0] row_blocks;
  wire [CW-1:0] blk_row;
  wire [CW-1:0] blk_col;
  wire [2*CW-1:0] row_start;
  wire [2*CW-1:0] blk_index;
  wire [AW-1:0] blk_offset;

  // Texel position and padding
  wire [1:0]    sub_x;
  wire [1:0]    sub_y;
  wire          outside;

  // Buffer and channel results
  wire          buf_ready;
  wire [BW-1:0] buf_in;
  wire [BW-1:0] buf_out;
  wire [31:0]   norm_val;

  // Format decoding, bit 0 signed, bit 1 two channels
  assign fmt_signed = fmt[0];                                    // RQ20
  assign fmt_dual   = fmt[1];                                    // RQ20

  // Block address from the request coordinates
  // Blocks per row: width rounded up to whole tiles
  assign row_blocks = {2'h0, i_req_width[CW-1:`RGTD_TILE_SHIFT]}
                      + (|i_req_width[1:0] ? {{(CW-1){1'b0}}, 1'b1}
                                           : {CW{1'b0}});       // RQ2
  // Tile row and column of the texel
  assign blk_row    = {2'h0, i_req_y[CW-1:`RGTD_TILE_SHIFT]};   // RQ2
  assign blk_col    = {2'h0, i_req_x[CW-1:`RGTD_TILE_SHIFT]};   // RQ2
  // Both factors widened so the product keeps every bit
  assign row_start  = {{CW{1'b0}}, row_blocks} * {{CW{1'b0}}, blk_row}; // RQ2
  assign blk_index  = row_start + {{CW{1'b0}}, blk_col};        // RQ2
  // Eight or sixteen bytes per block
  assign blk_offset = i_req_fmt[1]
                      ? blk_index[AW-1:0] << `RGTD_BLK2_SHIFT
                      : blk_index[AW-1:0] << `RGTD_BLK1_SHIFT;  // RQ1 RQ2

  // Position inside the 4x4 tile
  assign sub_x = i_req_x[1:0] & `RGTD_TILE_MASK;                // RQ3
  assign sub_y = i_req_y[1:0] & `RGTD_TILE_MASK;                // RQ3

  // Padding texels still decode, but are marked for the sampler
  // Compared against the image size, not the tile grid
  assign outside = (i_req_x >= i_req_width) | (i_req_y >= i_req_height); // RQ4

  // State register
  // Reset returns to idle, which raises o_req_ready
  always @(posedge i_clk) begin
    if (!i_rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Sequencing: one texel in flight, the buffer absorbs output stalls
  // A full buffer holds the sequencer in push, so no texel is lost
  always @* begin
    next_state = state;
    case (state)
      // Take a request
      ST_IDLE: begin
        if (i_req_valid)
          next_state = ST_FETCH;
      end
      // Hold the read until memory accepts
      ST_FETCH: begin
        if (i_mem_ready)
          next_state = ST_WAIT;
      end
      // Wait for the block
      ST_WAIT: begin
        if (i_mem_rvalid)
          next_state = ST_CALC;
      end
      // Results settle into the value registers
      ST_CALC: begin
        next_state = ST_PUSH;
      end
      // Leave once the buffer has room
      ST_PUSH: begin
        if (buf_ready)
          next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Request capture
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      fmt  <= `RGTD_FMT_U1;
      addr <= {AW{1'b0}};
      pos  <= 4'h0;
      pad  <= 1'b0;
      tag  <= {TW{1'b0}};
    end else if (state == ST_IDLE && i_req_valid) begin
      fmt  <= i_req_fmt;
      addr <= i_req_base + blk_offset;                          // RQ2
      pos  <= {sub_y, sub_x};                                   // RQ3 RQ7
      pad  <= outside;                                          // RQ4
      tag  <= i_req_tag;
    end
  end

  // Block capture; a one-channel block only fills the low half
  // Read data outside the wait state is ignored
  always @(posedge i_clk) begin
    if (!i_rst_n)
      blk <= 128'h0;
    else if (state == ST_WAIT && i_mem_rvalid)
      blk <= fmt_dual ? i_mem_rdata
             : {64'h0, i_mem_rdata[`RGTD_CHAN_BITS-1:0]};      // RQ1
  end

  // Handshakes
  assign o_req_ready = (state == ST_IDLE);

  // Read request: valid from the state, address and size registered
  assign o_mem_valid = (state == ST_FETCH);
  assign o_mem_addr  = addr;
  assign o_mem_wide  = fmt_dual;                                // RQ1

  // One decoder per channel: red from the low half, green from the high
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      // Blend terms of this channel
      wire [3:0]  w0;
      wire [3:0]  w1;
      wire        hi;
      wire [1:0]  lim;
      wire [8:0]  ep0;
      wire [8:0]  ep1;
      wire [13:0] p0;
      wire [13:0] p1;
      wire [13:0] num;
      wire [25:0] k;
      wire [39:0] prod;
      wire [39:0] scaled;
      reg  [15:0] val;

      // Selector, weights and endpoints of this half
      rgtd_chan u_chan (
        .i_blk    (blk[ch*`RGTD_CHAN_BITS +: `RGTD_CHAN_BITS]), // RQ17 RQ18
        .i_pos    (pos),
        .i_signed (fmt_signed),                                 // RQ18
        .o_w0     (w0),
        .o_w1     (w1),
        .o_hi     (hi),
        .o_lim    (lim),
        .o_ep0    (ep0),
        .o_ep1    (ep1)
      );

      // Weighted sum in code units, then one multiply for the division
      assign p0   = $signed({{5{ep0[8]}}, ep0}) * $signed({10'h000, w0});
      assign p1   = $signed({{5{ep1[8]}}, ep1}) * $signed({10'h000, w1});
      assign num  = p0 + p1;                                    // RQ8 RQ9
      assign k    = fmt_signed ? (hi ? K_S7 : K_S5)
                               : (hi ? K_U7 : K_U5);            // RQ12 RQ14
      assign prod = $signed({{26{num[13]}}, num}) * $signed({14'h0000, k});
      // Rounded, arithmetic shift keeps negative values exact
      assign scaled = $signed(prod + ROUND_HALF) >>> `RGTD_FRAC_SHIFT;

      // Range limits bypass the multiply
      always @* begin
        case (lim)
          `RGTD_LIM_MIN:
            val = fmt_signed ? `RGTD_VAL_NEG_ONE : `RGTD_VAL_ZERO; // RQ9 RQ14
          `RGTD_LIM_MAX:
            val = `RGTD_VAL_ONE;                                // RQ9 RQ14
          default:
            val = scaled[15:0];                                 // RQ11 RQ12
        endcase
      end

      // Both channels side by side for the result registers
      assign norm_val[ch*16 +: 16] = val;
    end
  endgenerate

  // Result registers, loaded once the block is held
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      val_r <= `RGTD_VAL_ZERO;
      val_g <= `RGTD_VAL_ZERO;
    end else if (state == ST_CALC) begin
      // Red always comes from the low half
      val_r <= norm_val[15:0];
      // Green is forced to zero for single-channel formats
      val_g <= fmt_dual ? norm_val[31:16] : `RGTD_VAL_ZERO;     // RQ13 RQ19
    end
  end

  // Output word: blue is always zero and alpha always one
  assign buf_in = {tag, pad, `RGTD_VAL_ONE, `RGTD_VAL_ZERO,
                   val_g, val_r};                               // RQ13 RQ19

  // The FSM waits in the push state while the buffer is full
  // This is the only stall point on the output side
  rgtd_buf #(
    .WIDTH (BW)
  ) u_buf (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (state == ST_PUSH),
    .o_in_ready  (buf_ready),
    .i_in_data   (buf_in),
    .o_out_valid (o_tex_valid),
    .i_out_ready (i_tex_ready),
    .o_out_data  (buf_out)
  );

  // Output unpacking
  assign o_tex_r   = buf_out[15:0];
  assign o_tex_g   = buf_out[31:16];
  assign o_tex_b   = buf_out[47:32];
  assign o_tex_a   = buf_out[63:48];

  // Side-band fields ride with the texel
  assign o_tex_pad = buf_out[64];
  assign o_tex_tag = buf_out[BW-1:65];

endmodule // rgtd_top

// ---- rgtd_top_assertions.sv ----
`timescale 1ns/1ps

module rgtd_top_checker #(
  parameter CW = 16,
  parameter AW = 32
) (
  // Clock, reset and request
  input wire logic          i_clk, i_rst_n, i_req_valid, o_req_ready,
  input wire logic [1:0]    i_req_fmt,
  input wire logic [AW-1:0] i_req_base, o_mem_addr,
  input wire logic [CW-1:0] i_req_width, i_req_x, i_req_y,
  // Memory and texel sides
  input wire logic          o_mem_valid, i_mem_ready, o_mem_wide, o_tex_valid, i_tex_ready,
  input wire logic [15:0]   o_tex_r, o_tex_g, o_tex_b, o_tex_a
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Expected block address, widened first so ceil(width/4) cannot wrap
  logic [AW-1:0] exp_addr;
  logic          exp_wide;
  assign exp_addr = i_req_base + ((((AW'(i_req_width) + 3) >> 2) * AW'(i_req_y >> 2)
                    + AW'(i_req_x >> 2)) << (i_req_fmt[1] ? 4 : 3));
  assign exp_wide = i_req_fmt[1];

  sequence s_take;
    i_req_valid && o_req_ready;
  endsequence
  sequence s_issue;
    o_mem_valid && !o_req_ready;
  endsequence

  AST_ISSUE: assert property (s_take |=> s_issue)
    else $error("block read not issued after take");
  AST_ADDR: assert property (s_take |=> o_mem_addr == $past(exp_addr))
    else $error("block address wrong");
  AST_WIDE: assert property (s_take |=> o_mem_wide == $past(exp_wide))
    else $error("block size wrong");
  AST_HOLD: assert property (o_mem_valid && !i_mem_ready |=>
    o_mem_valid && $stable(o_mem_addr) && $stable(o_mem_wide))
    else $error("read request dropped");
  AST_ONE_READ: assert property (o_mem_valid && i_mem_ready |=> !o_mem_valid)
    else $error("second read for one texel");
  AST_BUSY: assert property (s_take |=> !o_req_ready [*4])
    else $error("request taken too early");
  AST_PUSH: assert property ($rose(o_req_ready) |-> o_tex_valid)
    else $error("idle without texel");
  AST_CONST: assert property (o_tex_valid |-> o_tex_b == 16'h0000 && o_tex_a == 16'h4000)
    else $error("blue or alpha wrong");
  AST_TEX_HOLD: assert property (o_tex_valid && !i_tex_ready |=>
    o_tex_valid && $stable(o_tex_r) && $stable(o_tex_g))
    else $error("texel changed while stalled");
  AST_RANGE: assert property (o_tex_valid |-> $signed(o_tex_r) >= -16384
    && $signed(o_tex_r) <= 16384 && $signed(o_tex_g) >= -16384 && $signed(o_tex_g) <= 16384)
    else $error("texel out of range");
endmodule // rgtd_top_checker

bind rgtd_top rgtd_top_checker #(.CW(CW), .AW(AW)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
  .i_req_fmt(i_req_fmt), .i_req_base(i_req_base), .o_mem_addr(o_mem_addr),
  .i_req_width(i_req_width), .i_req_x(i_req_x), .i_req_y(i_req_y),
  .o_mem_valid(o_mem_valid), .i_mem_ready(i_mem_ready), .o_mem_wide(o_mem_wide),
  .o_tex_valid(o_tex_valid), .i_tex_ready(i_tex_ready), .o_tex_r(o_tex_r),
  .o_tex_g(o_tex_g), .o_tex_b(o_tex_b), .o_tex_a(o_tex_a));

// ---- testbench.sv ----
`timescale 1ns/1ps

module testbench;
  typedef struct packed {logic [15:0] r; logic [15:0] g; logic pad; logic [7:0] tag;} rgtd_exp_t;
  // Stimulus
  logic         i_clk = 1'b0, i_rst_n = 1'b0, i_req_valid = 1'b0, i_tex_ready = 1'b0;
  logic         slow = 1'b0, stall = 1'b0;
  logic [1:0]   i_req_fmt = 2'h0;
  logic [31:0]  i_req_base = 32'h0;
  logic [15:0]  i_req_width = 16'h0, i_req_height = 16'h0, i_req_x = 16'h0, i_req_y = 16'h0;
  logic [15:0]  w, h;
  logic [7:0]   i_req_tag = 8'h0;
  logic [127:0] blk = 128'h0, b;
  // Design answers
  wire          o_req_ready, o_mem_valid, i_mem_ready, o_mem_wide, i_mem_rvalid;
  wire          o_tex_valid, o_tex_pad;
  wire [31:0]   o_mem_addr;
  wire [127:0]  i_mem_rdata;
  wire [15:0]   o_tex_r, o_tex_g, o_tex_b, o_tex_a;
  wire [7:0]    o_tex_tag;
  integer       seed = 51694, err_total = 0, samples_checked = 0, i, k;
  rgtd_exp_t    q[$], e;

  always #25 i_clk = ~i_clk;

  rgtd_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req_fmt(i_req_fmt), .i_req_base(i_req_base),
    .i_req_width(i_req_width), .i_req_height(i_req_height), .i_req_x(i_req_x),
    .i_req_y(i_req_y), .i_req_tag(i_req_tag), .o_mem_valid(o_mem_valid),
    .i_mem_ready(i_mem_ready), .o_mem_addr(o_mem_addr), .o_mem_wide(o_mem_wide),
    .i_mem_rvalid(i_mem_rvalid), .i_mem_rdata(i_mem_rdata), .o_tex_valid(o_tex_valid),
    .i_tex_ready(i_tex_ready), .o_tex_r(o_tex_r), .o_tex_g(o_tex_g), .o_tex_b(o_tex_b),
    .o_tex_a(o_tex_a), .o_tex_pad(o_tex_pad), .o_tex_tag(o_tex_tag));

  rgtd_mem_model mem (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
    .i_mem_valid(o_mem_valid), .i_mem_wide(o_mem_wide), .i_blk(blk),
    .o_mem_ready(i_mem_ready), .o_mem_rvalid(i_mem_rvalid), .o_mem_rdata(i_mem_rdata));

  task end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task bad(input string m);
    err_total++;
    $display("BAD %0t %s", $time, m);
  endtask

  // Decoded values may be one step off after the reciprocal divide
  task cmp_near(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (!(got === exp || got === exp + 16'h1 || got === exp - 16'h1)) bad(m);
  endtask

  task cmp_eq(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) bad(m);
  endtask

  function real nrm(input logic [7:0] c, input logic sg);
    if (!sg) return c / 255.0;
    if (c == 8'h80) return -1.0;
    return $signed(c) / 127.0;
  endfunction

  // Expected channel value in 1.0 = 0x4000 fixed point
  function logic [15:0] chan(input logic [63:0] hb, input logic [3:0] p, input logic sg);
    integer s;
    real    a, c, v;
    s = hb[16 + 3 * p +: 3];
    a = nrm(hb[7:0], sg);
    c = nrm(hb[15:8], sg);
    if (s < 2) v = s ? c : a;
    else if (sg ? $signed(hb[7:0]) > $signed(hb[15:8]) : hb[7:0] > hb[15:8])
      v = ((8 - s) * a + (s - 1) * c) / 7.0;
    else case (s)
      2: v = (3 * a + 2 * c) / 5.0;
      3: v = (4 * a + c) / 5.0;
      4: v = (2 * a + 3 * c) / 5.0;
      5: v = (a + 4 * c) / 5.0;
      6: v = sg ? -1.0 : 0.0;
      default: v = 1.0;
    endcase
    return 16'(int'(v * 16384.0));
  endfunction

  // Waits until idle, then presents one request for exactly one edge
  task req(input logic [1:0] f, input logic [15:0] wd, ht, x, y, input logic [127:0] bk);
    @(posedge i_clk);
    k = 0;
    while (o_req_ready !== 1'b1 && k < 500) begin
      @(posedge i_clk);
      k++;
    end
    e.r   = chan(bk[63:0], {y[1:0], x[1:0]}, f[0]);
    e.g   = f[1] ? chan(bk[127:64], {y[1:0], x[1:0]}, f[0]) : 16'h0000;
    e.pad = (x >= wd) || (y >= ht);
    e.tag = i_req_tag + 8'h1;
    q.push_back(e);
    i_req_fmt   <= f;
    i_req_width <= wd;
    i_req_height <= ht;
    i_req_x     <= x;
    i_req_y     <= y;
    i_req_tag   <= e.tag;
    i_req_base  <= {$random(seed)} & 32'hFFFFFFF0;
    blk         <= bk;
    i_req_valid <= 1'b1;
    @(posedge i_clk);
    i_req_valid <= 1'b0;
  endtask

  task drain;
    k = 0;
    while (q.size() != 0 && k < 2000) begin
      @(posedge i_clk);
      k++;
    end
    if (q.size() != 0) bad("texels missing");
  endtask

  // Consumer takes texels at random unless told to stall
  always @(posedge i_clk) i_tex_ready <= stall ? 1'b0 : (($random(seed) & 3) != 0);

  // Compare each popped texel with the oldest expectation
  always @(posedge i_clk) begin : mon
    rgtd_exp_t x;
    if (i_rst_n && o_tex_valid === 1'b1 && i_tex_ready === 1'b1) begin
      if (q.size() == 0) bad("texel without request");
      else begin
        x = q.pop_front();
        cmp_eq({15'h0, o_tex_pad}, {15'h0, x.pad}, "pad flag");
        cmp_eq({8'h0, o_tex_tag}, {8'h0, x.tag}, "texel order");
        cmp_eq(o_tex_a, 16'h4000, "alpha");
        if (!x.pad) cmp_near(o_tex_r, x.r, "red");
        if (!x.pad) cmp_near(o_tex_g, x.g, "green");
      end
    end
  end

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    cmp_eq({13'h0, o_req_ready, o_mem_valid, o_tex_valid}, 16'h0004, "reset state");
    $display("test reset done");
    // Every format, every selector, both endpoint orders
    for (i = 0; i < 64; i++) begin
      b[63:0]   = {{16{i[3:1]}}, i[0] ? 16'h7080 : 16'h8070};
      b[127:64] = {{16{i[3:1]}}, i[0] ? 16'h8070 : 16'h7080};
      req(i[5:4], 16'h8, 16'h8, 16'($random(seed) & 3), 16'($random(seed) & 3), b);
    end
    $display("test corners done");
    // Random blocks and coordinates, memory and consumer stalling
    slow <= 1'b1;
    for (i = 0; i < 150; i++) begin
      w = 16'(1 + ({$random(seed)} % 40));
      h = 16'(1 + ({$random(seed)} % 40));
      b = {$random(seed), $random(seed), $random(seed), $random(seed)};
      if (b[15:0] == 16'h8081) b[7:0] = 8'h7F;
      if (b[79:64] == 16'h8081) b[71:64] = 8'h7F;
      req(2'($random(seed)), w, h, 16'({$random(seed)} % (w + 2)),
          16'({$random(seed)} % (h + 2)), b);
    end
    drain();
    $display("test random done");
    // Two texels fill the buffer, the third must wait inside the decoder
    stall <= 1'b1;
    repeat (3) req(2'h3, 16'h10, 16'h10, 16'($random(seed) & 15), 16'h5, b);
    repeat (30) @(posedge i_clk);
    cmp_eq({15'h0, o_req_ready}, 16'h0000, "request taken while full");
    stall <= 1'b0;
    drain();
    $display("test buffer done");
    end_of_test();
  end

  // Roughly fifteen to twenty times the expected run length
  initial begin
    repeat (40000) @(posedge i_clk);
    bad("watchdog expired");
    end_of_test();
  end
endmodule // testbench
